// ### bench/mbs_barrier_seq_assertions.sv
// Purpose: port-level checks of the memory barrier sequencer
// Assumes: bench holds the export bit stable while a barrier runs
// Notes: bound onto every instance of the sequencer
`timescale 1ns/1ps
module mbs_barrier_seq_checker (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // stimulus seen at the block
  input wire mbs_pkg::mbs_cfg_t cfg,
  input wire mbs_pkg::mbs_queues_t queues,
  input wire mbs_pkg::mbs_fill_t fill,
  input wire logic fullBarrierAtMap,
  input wire logic missTxnIssue,
  input wire logic commitProbe,
  input wire logic commitSysData,
  input wire logic barrierDoneResponse,
  input wire logic probeQueueEmpty,
  // block outputs
  input wire logic mapStall,
  input wire logic fullBarrierRelease,
  input wire logic writeBarrierDone,
  input wire logic [mbs_pkg::SB_WIDTH-1:0] scoreboard,
  input wire logic fetchStall,
  input wire logic resumePrefetch,
  input wire logic mafIowbStall,
  input wire logic iowbSend,
  input wire logic barrierCmd,
  input wire logic markProbe,
  input wire logic [mbs_pkg::UTC_WIDTH-1:0] uncommittedTxnCount
);
  import mbs_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////
  AST_SATURATE: assert property (uncommittedTxnCount == 4'hf |-> mafIowbStall)
    else $error("miss path not stalled at full count");
  AST_NO_COUNT_EXPORT: assert property (cfg.systemBarrierExport |=>
    uncommittedTxnCount <= $past(uncommittedTxnCount)) else $error("count rose in export mode");
  AST_INCREMENT: assert property ((missTxnIssue && !iowbSend && !cfg.systemBarrierExport
    && !commitProbe && !commitSysData && uncommittedTxnCount != 4'hf)
    |=> uncommittedTxnCount == $past(uncommittedTxnCount) + 4'h1) else $error("no increment");
  AST_DECREMENT: assert property ((commitProbe && !commitSysData && !missTxnIssue
    && !iowbSend && uncommittedTxnCount != 4'h0)
    |=> uncommittedTxnCount == $past(uncommittedTxnCount) - 4'h1) else $error("no decrement");
  AST_FLOOR: assert property ((uncommittedTxnCount == 4'h0 && !missTxnIssue && !iowbSend)
    |=> uncommittedTxnCount == 4'h0) else $error("count went below zero");
  AST_MAP_HOLD: assert property ((fullBarrierAtMap && !fullBarrierRelease) |-> mapStall)
    else $error("younger work not held at map");
  AST_RELEASE_DRAINED: assert property (fullBarrierRelease |->
    queues.mafDstreamEmpty && queues.storeQueueEmpty && queues.loadQueueEmpty)
    else $error("release with queues busy");
  AST_CMD_EXPORT_ONLY: assert property (barrierCmd |-> cfg.systemBarrierExport)
    else $error("barrier command in internal mode");
  AST_ACK_MARKS: assert property (barrierDoneResponse |-> markProbe)
    else $error("acknowledge did not mark probe");
  AST_FILL_QUEUED: assert property (fill.dataFillQueued |=> scoreboard[4] && scoreboard[0])
    else $error("scoreboard bits not set");
  AST_RESUME: assert property (resumePrefetch |-> fetchStall && probeQueueEmpty)
    else $error("resume before probe queue drained");
  COV_CMD: cover property (barrierCmd);
  COV_WB_DONE: cover property (writeBarrierDone);
  COV_RESUME: cover property (resumePrefetch);
endmodule
//////////////////////////////////////////////////////////////////////
bind mbs_barrier_seq mbs_barrier_seq_checker chk_u (.*);

// ### bench/mbs_sys_model.sv
// Purpose: chipset side of the system port for the barrier sequencer
// Assumes: one barrier command or marked probe outstanding at a time
// Notes: slow stretches both answers to six cycles
`timescale 1ns/1ps
module mbs_sys_model (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // requests from the block
  input wire logic barrierCmd,
  input wire logic markProbe,
  input wire logic cntIncr,
  // behaviour select
  input wire logic slow,
  input wire logic commitOn,
  // answers
  output logic barrierDoneResponse,
  output logic markedProbeRespSent,
  output logic commitSysData
);
  int ackWait;
  int respWait;
  int pending;
  always @(posedge clock) begin
    if (srst) begin
      ackWait <= 0;
      respWait <= 0;
      pending <= 0;
      barrierDoneResponse <= 1'b0;
      markedProbeRespSent <= 1'b0;
      commitSysData <= 1'b0;
    end else begin
      // every command answered, also one whose barrier was killed
      if (barrierCmd) ackWait <= slow ? 6 : 1;
      else if (ackWait > 0) ackWait <= ackWait - 1;
      barrierDoneResponse <= (ackWait == 1);
      if (markProbe) respWait <= slow ? 6 : 1;
      else if (respWait > 0) respWait <= respWait - 1;
      markedProbeRespSent <= (respWait == 1);
      // commit carried on a fill response, one per two cycles
      commitSysData <= commitOn && pending > 0 && !commitSysData;
      pending <= pending + int'(cntIncr) - int'(commitSysData);
    end
  end
endmodule

// ### bench/memory_barrier_sequencer_bench.sv
// Purpose: directed tests of the memory barrier sequencer
// Assumes: merge idle timeout shortened to 8 cycles
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module memory_barrier_sequencer_bench;
  import mbs_pkg::*;
  mbs_cfg_t cfg;
  mbs_queues_t queues;
  mbs_fill_t fill;
  logic clock, srst, fullBarrierAtMap, writeBarrierReady, missTxnIssue, ioStoreAlloc;
  logic ioLoadIssue, sysPortReady, commitProbe, probeQueueEmpty, commitSysData;
  logic barrierDoneResponse, markedProbeRespSent, mapStall, fullBarrierRelease;
  logic writablePtrStall, writeBarrierDone, fetchStall, resumePrefetch, mafIowbStall;
  logic flushPending, iowbFull, iowbSend, mergeOpen, barrierCmd, markProbe, slow, commitOn;
  logic [SB_WIDTH-1:0] scoreboard;
  logic [UTC_WIDTH-1:0] uncommittedTxnCount;
  logic [7:0] marks, cmds;
  int num_errors, compares;
  mbs_barrier_seq #(.MERGE_IDLE(8)) dut_u (.*);
  mbs_sys_model sys_u (.clock(clock), .srst(srst), .barrierCmd(barrierCmd),
    .markProbe(markProbe), .cntIncr(missTxnIssue | iowbSend), .slow(slow),
    .commitOn(commitOn), .barrierDoneResponse(barrierDoneResponse),
    .markedProbeRespSent(markedProbeRespSent), .commitSysData(commitSysData));
  //////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (markProbe === 1'b1) marks <= marks + 8'h01;
    if (barrierCmd === 1'b1) cmds <= cmds + 8'h01;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return fullBarrierRelease;
      1: return barrierCmd;
      2: return writeBarrierDone;
      3: return flushPending;
      default: return !scoreboard[SB_MEM_BIT];
    endcase
  endfunction
  // bounded wait, a pulse is caught in its own cycle
  task automatic wait_hi(input int k);
    int i;
    i = 0;
    while (sel(k) !== 1'b1 && i < 100) begin
      step(1);
      i++;
    end
    chk(8'(sel(k)), 8'h01);
  endtask
  task automatic issue(input int n);
    missTxnIssue = 1'b1;
    step(n);
    missTxnIssue = 1'b0;
  endtask
  task automatic commit();
    commitProbe = 1'b1;
    step(1);
    commitProbe = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    {fullBarrierAtMap, writeBarrierReady, missTxnIssue, ioStoreAlloc} = 4'h0;
    {ioLoadIssue, sysPortReady, commitProbe, slow, commitOn} = 5'h00;
    cfg = '0;
    fill = '0;
    queues = 5'h1f;
    probeQueueEmpty = 1'b1;
    marks = 8'h00;
    cmds = 8'h00;
    srst = 1'b1;
    step(8);
    srst = 1'b0;
    chk(8'(uncommittedTxnCount), 8'h00);
    chk(8'({scoreboard, fetchStall, mergeOpen}), 8'h00);
    issue(3);
    chk(8'(uncommittedTxnCount), 8'h03);
    commit();
    chk(8'(uncommittedTxnCount), 8'h02);
    commitOn = 1'b1;
    step(8);
    commitOn = 1'b0;
    chk(8'(uncommittedTxnCount), 8'h00);
    commit();
    chk(8'(uncommittedTxnCount), 8'h00);
    issue(15);
    chk(8'({mafIowbStall, uncommittedTxnCount}), 8'h1f);
    commit();
    chk(8'({mafIowbStall, uncommittedTxnCount}), 8'h0e);
    commitOn = 1'b1;
    step(40);
    commitOn = 1'b0;
    $display("test counter done");
    slow = 1'b1;
    issue(1);
    queues.iqEmpty = 1'b0;
    fullBarrierAtMap = 1'b1;
    step(4);
    chk(8'({mapStall, flushPending}), 8'h02);
    queues.iqEmpty = 1'b1;
    wait_hi(3);
    step(4);
    chk(marks, 8'h00);
    commit();
    step(2);
    chk(marks, 8'h01);
    chk(8'(mapStall), 8'h01);
    wait_hi(0);
    fullBarrierAtMap = 1'b0;
    chk(cmds, 8'h00);
    cfg.systemBarrierExport = 1'b1;
    fullBarrierAtMap = 1'b1;
    wait_hi(1);
    step(2);
    chk(marks, 8'h01);
    wait_hi(0);
    fullBarrierAtMap = 1'b0;
    chk(marks, 8'h02);
    issue(2);
    chk(8'(uncommittedTxnCount), 8'h00);
    $display("test full barrier done");
    for (int e = 0; e < 2; e++) begin
      cfg.systemBarrierExport = e[0];
      ioStoreAlloc = 1'b1;
      step(1);
      ioStoreAlloc = 1'b0;
      chk(8'(mergeOpen), 8'h01);
      writeBarrierReady = 1'b1;
      step(1);
      chk(8'({writablePtrStall, mafIowbStall, mergeOpen}), 8'h06);
      wait_hi(2);
      writeBarrierReady = 1'b0;
      chk(cmds, 8'(e + 1));
    end
    $display("test write barrier done");
    cfg.systemBarrierExport = 1'b0;
    ioStoreAlloc = 1'b1;
    step(2);
    ioStoreAlloc = 1'b0;
    chk(8'(iowbFull), 8'h01);
    ioLoadIssue = 1'b1;
    step(1);
    ioLoadIssue = 1'b0;
    chk(8'(mergeOpen), 8'h00);
    sysPortReady = 1'b1;
    step(10);
    chk(8'({iowbFull, uncommittedTxnCount}), 8'h04);
    sysPortReady = 1'b0;
    ioStoreAlloc = 1'b1;
    step(1);
    ioStoreAlloc = 1'b0;
    step(5);
    chk(8'(mergeOpen), 8'h01);
    step(8);
    chk(8'(mergeOpen), 8'h00);
    sysPortReady = 1'b1;
    commitOn = 1'b1;
    step(30);
    chk(8'(uncommittedTxnCount), 8'h00);
    $display("test io buffer done");
    cfg.xlateFillBarrierEnable = 1'b1;
    fill.dataFillQueued = 1'b1;
    step(1);
    fill.dataFillQueued = 1'b0;
    chk(8'(scoreboard), 8'h11);
    fill.dataFillIssued = 1'b1;
    step(1);
    fill.dataFillIssued = 1'b0;
    chk(8'(scoreboard[SB_MEM_BIT]), 8'h01);
    wait_hi(4);
    chk(marks, 8'h05);
    cfg.xlateFillBarrierEnable = 1'b0;
    fill.instrFillQueued = 1'b1;
    step(1);
    fill.instrFillQueued = 1'b0;
    fill.instrFillIssued = 1'b1;
    step(1);
    fill.instrFillIssued = 1'b0;
    chk(8'(scoreboard), 8'h00);
    step(10);
    chk(marks, 8'h05);
    cfg.xlateFillBarrierEnable = 1'b1;
    probeQueueEmpty = 1'b0;
    fill.instrPteLoadDone = 1'b1;
    step(1);
    fill.instrPteLoadDone = 1'b0;
    step(2);
    chk(8'(fetchStall), 8'h01);
    probeQueueEmpty = 1'b1;
    #1;
    chk(8'(resumePrefetch), 8'h01);
    step(1);
    chk(8'(fetchStall), 8'h00);
    $display("test fill done");
    end_sim();
  end
endmodule

// ### src/mbs_barrier_seq.sv
// Purpose: sequences full barriers, write barriers and translation-fill barriers
// Assumes: requests are level inputs held until the matching done pulse
// Notes: the io write buffer occupancy and merge window live here
`timescale 1ns/1ps
module mbs_barrier_seq #(
  parameter int IO_WRITE_BUFFER_DEPTH = mbs_pkg::IO_WRITE_BUFFER_ENTRIES,
  parameter int MERGE_IDLE = mbs_pkg::MERGE_IDLE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // configuration
  input wire mbs_pkg::mbs_cfg_t cfg,
  // pipeline side
  input wire logic fullBarrierAtMap,
  input wire logic writeBarrierReady,
  input wire mbs_pkg::mbs_queues_t queues,
  input wire mbs_pkg::mbs_fill_t fill,
  output logic mapStall,
  output logic fullBarrierRelease,
  output logic writablePtrStall,
  output logic writeBarrierDone,
  output logic [mbs_pkg::SB_WIDTH-1:0] scoreboard,
  output logic fetchStall,
  output logic resumePrefetch,
  // miss file and io write path
  input wire logic missTxnIssue,
  input wire logic ioStoreAlloc,
  input wire logic ioLoadIssue,
  input wire logic sysPortReady,
  output logic mafIowbStall,
  output logic flushPending,
  output logic iowbFull,
  output logic iowbSend,
  output logic mergeOpen,
  // system port side
  input wire logic commitProbe,
  input wire logic commitSysData,
  input wire logic barrierDoneResponse,
  input wire logic markedProbeRespSent,
  input wire logic probeQueueEmpty,
  output logic barrierCmd,
  output logic markProbe,
  output logic [mbs_pkg::UTC_WIDTH-1:0] uncommittedTxnCount
);
  import mbs_pkg::*;

  initial begin
    if (IO_WRITE_BUFFER_DEPTH < 1 || IO_WRITE_BUFFER_DEPTH > 15) $error("mbs_barrier_seq: IO_WRITE_BUFFER_DEPTH out of range");
    if (MERGE_IDLE < 2 || MERGE_IDLE > 65535) $error("mbs_barrier_seq: MERGE_IDLE out of range");
  end

  localparam logic [3:0] IO_WRITE_BUFFER_LAST = 4'(IO_WRITE_BUFFER_DEPTH);
  localparam logic [15:0] IDLE_LAST = 16'(MERGE_IDLE - 1);

  typedef struct packed {
    mbs_state_t st;
    logic isWrite;
    logic isInject;
    logic exportMode;
    logic respSeen;
    logic pendingInject;
    logic [SB_WIDTH-1:0] sb;
    logic fetchStall;
    logic [3:0] iowbCount;
    logic mergeOpen;
    logic [15:0] mergeIdle;
  } mbs_seq_state_t;

  mbs_seq_state_t cur;
  mbs_seq_state_t next_cur;

  logic cntSat;
  logic cntOneToZero;
  logic [UTC_WIDTH-1:0] cnt;
  logic active;
  logic drained;
  logic done;
  logic sendNow;
  logic startFull;
  logic startWrite;
  logic startInject;
  logic closeMerge;
  logic fillIssued;
  logic [IO_WRITE_BUFFER_DEPTH-1:0] iowbValid;

  ////////////////////////////////////////////////////////////////////////////
  // shared decodes

  // only a plain full barrier lets younger work leave the map stage
  function automatic logic full_done(input logic d, input logic w, input logic inj);
    return d && !w && !inj;
  endfunction

  // already-zero counter marks at once, else wait for the one-to-zero step
  function automatic logic zero_reached(input logic step, input logic [UTC_WIDTH-1:0] c);
    return step || (c == '0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // io write buffer entry view

  // entry i holds data while the occupancy count is above it
  generate
    for (genvar i = 0; i < IO_WRITE_BUFFER_DEPTH; i++) begin : g_io_write_buffer
      assign iowbValid[i] = (cur.iowbCount > 4'(i));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // uncommitted transaction counter

  // increments count only in the internal completion mode; commits count down in both modes
  mbs_txn_counter #(
    .WIDTH(UTC_WIDTH)
  ) u_txn_counter (
    .clock(clock),
    .srst(srst),
    .countEnable(!cfg.systemBarrierExport),
    .incr(missTxnIssue || iowbSend),
    .commitProbe(commitProbe),
    .commitSysData(commitSysData),
    .count(cnt),
    .saturated(cntSat),
    .oneToZero(cntOneToZero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // combinational decisions

  always_comb begin
    active = (cur.st != MBS_IDLE);
    drained = queues.mafDstreamEmpty && queues.storeQueueEmpty && queues.loadQueueEmpty
              && (cur.iowbCount == 4'h0);
    // injected barriers take precedence, then full, then write barriers
    startInject = (cur.st == MBS_IDLE) && cur.pendingInject;
    startFull = (cur.st == MBS_IDLE) && !cur.pendingInject && fullBarrierAtMap;
    startWrite = (cur.st == MBS_IDLE) && !cur.pendingInject && !fullBarrierAtMap
                 && writeBarrierReady;
    done = (cur.st == MBS_WAITRESP) && (cur.respSeen || markedProbeRespSent)
           && (cur.isWrite || drained);
    fillIssued = fill.dataFillIssued || fill.instrFillIssued;
    // any barrier start or io load ends the merge window
    closeMerge = startFull || startWrite || startInject || ioLoadIssue;
    // writes and the saturated counter both hold the miss file and io buffer
    mafIowbStall = cntSat || (active && cur.isWrite);
    // a merging entry is not sent until its window closes
    sendNow = (cur.iowbCount != 4'h0) && !mafIowbStall && sysPortReady
              && !(cur.mergeOpen && cur.iowbCount == 4'h1);
  end

  assign iowbSend = sendNow;
  assign iowbFull = iowbValid[IO_WRITE_BUFFER_DEPTH-1];
  assign mapStall = fullBarrierAtMap && !full_done(done, cur.isWrite, cur.isInject);
  assign fullBarrierRelease = full_done(done, cur.isWrite, cur.isInject);
  assign writeBarrierDone = done && cur.isWrite;
  assign writablePtrStall = writeBarrierReady;
  assign flushPending = (cur.st == MBS_FLUSH);
  assign barrierCmd = (cur.st == MBS_SENDCMD);
  assign markProbe = ((cur.st == MBS_WAITACK) && barrierDoneResponse)
                     || ((cur.st == MBS_WAITZERO) && zero_reached(cntOneToZero, cnt));
  assign resumePrefetch = cur.fetchStall && probeQueueEmpty;
  assign scoreboard = cur.sb;
  assign fetchStall = cur.fetchStall;
  assign mergeOpen = cur.mergeOpen;
  assign uncommittedTxnCount = cnt;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_cur = cur;
    case (cur.st)
      MBS_IDLE: begin
        next_cur.respSeen = 1'b0;
        next_cur.exportMode = cfg.systemBarrierExport;
        if (startInject) begin
          next_cur.isWrite = 1'b0;
          next_cur.isInject = 1'b1;
          next_cur.st = MBS_FLUSH;
        end else if (startFull) begin
          next_cur.isWrite = 1'b0;
          next_cur.isInject = 1'b0;
          next_cur.st = MBS_WAITIQ;
        end else if (startWrite) begin
          next_cur.isWrite = 1'b1;
          next_cur.isInject = 1'b0;
          next_cur.st = cfg.systemBarrierExport ? MBS_SENDCMD : MBS_WAITZERO;
        end
      end
      MBS_WAITIQ: begin
        if (queues.iqEmpty) begin
          next_cur.st = MBS_FLUSH;
        end
      end
      MBS_FLUSH: begin
        if (queues.mafPendingEmpty && (cur.iowbCount == 4'h0)) begin
          next_cur.st = cur.exportMode ? MBS_SENDCMD : MBS_WAITZERO;
        end
      end
      MBS_SENDCMD: begin
        next_cur.st = MBS_WAITACK;
      end
      MBS_WAITACK: begin
        // relies on the system answering every command it is sent
        if (barrierDoneResponse) begin
          next_cur.st = MBS_WAITRESP;
        end
      end
      MBS_WAITZERO: begin
        if (zero_reached(cntOneToZero, cnt)) begin
          next_cur.st = MBS_WAITRESP;
        end
      end
      MBS_WAITRESP: begin
        if (markedProbeRespSent) begin
          next_cur.respSeen = 1'b1;
        end
        if (done) begin
          next_cur.st = MBS_IDLE;
          if (cur.isInject) begin
            next_cur.pendingInject = 1'b0;
          end
        end
      end
      default: begin
        next_cur.st = MBS_IDLE;
      end
    endcase

    // scoreboard: clears first so a new queued fill in the same cycle wins
    if (fillIssued) begin
      next_cur.sb[SB_FILL_BIT] = 1'b0;
      if (cfg.xlateFillBarrierEnable) begin
        next_cur.pendingInject = 1'b1;
      end else begin
        next_cur.sb[SB_MEM_BIT] = 1'b0;
      end
    end
    if (done && cur.isInject) begin
      next_cur.sb[SB_MEM_BIT] = 1'b0;
    end
    if (fill.dataFillQueued || fill.instrFillQueued) begin
      next_cur.sb[SB_FILL_BIT] = 1'b1;
      next_cur.sb[SB_MEM_BIT] = 1'b1;
    end

    // instruction fill fetch stall; a new load done wins over the release
    if (cur.fetchStall && probeQueueEmpty) begin
      next_cur.fetchStall = 1'b0;
    end
    if (fill.instrPteLoadDone && cfg.xlateFillBarrierEnable) begin
      next_cur.fetchStall = 1'b1;
    end

    // io write buffer occupancy
    next_cur.iowbCount = cur.iowbCount
                         + {3'b000, ioStoreAlloc && !iowbFull}
                         - {3'b000, sendNow};

    // merge window: open on a store, close on idle timeout, barrier start or io load
    if (ioStoreAlloc && !iowbFull) begin
      next_cur.mergeOpen = 1'b1;
      next_cur.mergeIdle = 16'h0000;
    end else if (cur.mergeOpen) begin
      if (cur.mergeIdle == IDLE_LAST) begin
        next_cur.mergeOpen = 1'b0;
        next_cur.mergeIdle = 16'h0000;
      end else begin
        next_cur.mergeIdle = cur.mergeIdle + 16'h0001;
      end
    end
    if (closeMerge) begin
      next_cur.mergeOpen = 1'b0;
      next_cur.mergeIdle = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock) begin
    if (srst) begin
      cur.st <= MBS_IDLE;
      cur.isWrite <= 1'b0;
      cur.isInject <= 1'b0;
      cur.exportMode <= 1'b0;
      cur.respSeen <= 1'b0;
      cur.pendingInject <= 1'b0;
      cur.sb <= SB_RESET;
      cur.fetchStall <= 1'b0;
      cur.iowbCount <= 4'h0;
      cur.mergeOpen <= 1'b0;
      cur.mergeIdle <= 16'h0000;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

// ### src/mbs_pkg.sv
// Purpose: shared constants and carrier types of the memory barrier sequencer
// Assumes: one core clock, synchronous active-high reset
// Notes: all timeouts are in core clock cycles
package mbs_pkg;

  // uncommitted transaction counter
  localparam int UTC_WIDTH = 4;
  localparam logic [3:0] UTC_RESET = 4'h0;

  // io write buffer geometry
  localparam int IO_WRITE_BUFFER_ENTRIES = 4;
  localparam int IO_WRITE_BUFFER_ENTRY_BYTES = 64;

  // merge window idle timeout, in cycles
  localparam int MERGE_IDLE_CYCLES = 1024;

  // privileged register scoreboard
  localparam int SB_WIDTH = 5;
  localparam int SB_FILL_BIT = 4;
  localparam int SB_MEM_BIT = 0;
  localparam logic [4:0] SB_RESET = 5'h00;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    MBS_IDLE     = 7'h01,
    MBS_WAITIQ   = 7'h02,
    MBS_FLUSH    = 7'h04,
    MBS_SENDCMD  = 7'h08,
    MBS_WAITACK  = 7'h10,
    MBS_WAITZERO = 7'h20,
    MBS_WAITRESP = 7'h40
  } mbs_state_t;

  // configuration bits
  typedef struct packed {
    logic systemBarrierExport;
    logic xlateFillBarrierEnable;
  } mbs_cfg_t;

  // drain status of the memory queues
  typedef struct packed {
    logic iqEmpty;
    logic mafDstreamEmpty;
    logic mafPendingEmpty;
    logic storeQueueEmpty;
    logic loadQueueEmpty;
  } mbs_queues_t;

  // translation fill events, one-cycle pulses
  typedef struct packed {
    logic dataFillQueued;
    logic dataFillIssued;
    logic instrFillQueued;
    logic instrFillIssued;
    logic instrPteLoadDone;
  } mbs_fill_t;

endpackage

// ### src/mbs_txn_counter.sv
// Purpose: saturating counter of uncommitted system transactions
// Assumes: increments are stalled upstream while saturated
// Notes: two commit sources may arrive in the same cycle
`timescale 1ns/1ps
module mbs_txn_counter #(
  parameter int WIDTH = mbs_pkg::UTC_WIDTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic countEnable,
  input wire logic incr,
  input wire logic commitProbe,
  input wire logic commitSysData,
  // status
  output logic [WIDTH-1:0] count,
  output logic saturated,
  output logic oneToZero
);
  import mbs_pkg::*;

  initial begin
    if (WIDTH < 2 || WIDTH > 8) $error("mbs_txn_counter: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } mbs_cnt_state_t;

  localparam logic [WIDTH+1:0] MAXV = {2'b00, {WIDTH{1'b1}}};

  mbs_cnt_state_t cur;
  mbs_cnt_state_t next_cur;
  logic [WIDTH+1:0] sum;
  logic [WIDTH+1:0] dec;

  always_comb begin
    next_cur = cur;
    sum = {2'b00, cur.count};
    if (countEnable && incr && (cur.count != MAXV[WIDTH-1:0])) begin
      sum = sum + {{(WIDTH+1){1'b0}}, 1'b1};
    end
    // commits are honoured at any nonzero count, also while saturated; a commit at zero leaves zero
    dec = {{(WIDTH+1){1'b0}}, commitProbe} + {{(WIDTH+1){1'b0}}, commitSysData};
    if (sum >= dec) begin
      sum = sum - dec;
    end else begin
      sum = '0;
    end
    if (sum > MAXV) begin
      sum = MAXV;
    end
    next_cur.count = sum[WIDTH-1:0];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur.count <= WIDTH'(UTC_RESET);
    end else begin
      cur <= next_cur;
    end
  end

  assign count = cur.count;
  assign saturated = (cur.count == MAXV[WIDTH-1:0]);
  assign oneToZero = (cur.count == {{(WIDTH-1){1'b0}}, 1'b1}) && (next_cur.count == '0);

endmodule
